// File: hw/aiss_regs.vh
`ifndef AISS_REGS_VH
`define AISS_REGS_VH
// ********************************************
// register offsets (byte addresses)
// ********************************************
`define AISS_CTRL_ADDR      12'h000
`define AISS_CFG_ADDR       12'h004
`define AISS_STAT_ADDR      12'h008
`define AISS_REFT_ADDR      12'h00C
`define AISS_TIME_ADDR      12'h010
`define AISS_ADDR_LSB       2
`define AISS_ADDR_W         12
// ********************************************
// control fields
// ********************************************
`define AISS_CTRL_PARAM     0
`define AISS_CTRL_RUN       1
// ********************************************
// configuration fields
// ********************************************
`define AISS_CFG_ACT_LO     0
`define AISS_CFG_ACT_HI     7
`define AISS_CFG_SMO_LO     8
`define AISS_CFG_SMO_HI     9
`define AISS_CFG_FMT        10
`define AISS_CFG_SUP        11
`define AISS_CFG_RJ_LO      12
`define AISS_CFG_RJ_HI      13
`define AISS_CFG_RNG_LO     16
`define AISS_CFG_RNG_HI     19
// ********************************************
// reset values and codes
// ********************************************
`define AISS_SMO_NONE       2'h0
`define AISS_FMT_PRIMARY    1'b0
`define AISS_SUP_50HZ       1'b0
`define AISS_RJ_NONE        2'h0
`define AISS_REFT_RST       16'h0000
`define AISS_INVALID        16'h7FFF
// default ranges by module type
`define AISS_TYPE_VOLT      2'h0
`define AISS_TYPE_CURR      2'h1
`define AISS_TYPE_RES       2'h2
`define AISS_TYPE_TC        2'h3
`define AISS_RNG_10V        4'h1
`define AISS_RNG_4_20MA     4'h3
`define AISS_RNG_PT100      4'h5
`define AISS_RNG_TC_K       4'h9
// ********************************************
// timing: integration and processing times in microseconds, clock in MHz
// ********************************************
`define AISS_INT_50HZ_US    20000
`define AISS_INT_60HZ_US    16667
`define AISS_PROC_US        1000
`define AISS_CLK_MHZ        125
`endif

// File: hw/aiss_smooth.v
`timescale 1ns/1ps
// ********************************************
// first-order smoothing filter, one channel
// ********************************************
module aiss_smooth #(
    parameter W = 16
) (
    input  wire         clk_i,
    input  wire         nrst_i,
    input  wire         load_i,    // raw sample arrives
    input  wire         seed_i,    // take sample unfiltered
    input  wire [1:0]   level_i,   // 0 none .. 3 strong
    input  wire [W-1:0] raw_i,
    output wire [W-1:0] val_o
);
    reg  [W-1:0] acc_q;           // filtered value
    wire [1:0]   sh;              // shift = time constant
    wire signed [W:0] diff;
    wire signed [W:0] step;       // error scaled by the time constant
    assign sh   = level_i;
    assign diff = $signed({raw_i[W-1], raw_i}) -
                  $signed({acc_q[W-1], acc_q});
    // arithmetic shift keeps the sign of a falling input
    assign step = diff >>> sh;
    // stronger level: longer time constant
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_q <= {W{1'b0}};
        end else if (load_i) begin
            if (seed_i || sh == 2'h0) begin
                acc_q <= raw_i;
            end else begin
                acc_q <= acc_q + step[W-1:0];
            end
        end
    end
    assign val_o = acc_q;
endmodule // aiss_smooth

// File: hw/aiss_top.v
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`include "aiss_regs.vh"
// Functional notes
// - restart defaults: 50 Hz, no smoothing, primary
// - default range follows module type
// - no load supply: every channel invalid
// - otherwise report converted process value, invalid until a channel's first conversion
// - channels converted strictly one at a time
// - cycle time sums active channel times plus one cycle per inactive channel
// - channel time: integration plus processing
// - deactivated channel is skipped in a single pick cycle
// - selectable none/weak/medium/strong smoothing
// - primary or legacy number format
module aiss_top #(
    parameter NCH      = 8,
    parameter [1:0] MOD_TYPE = 2'h0,
    parameter INT50_CYC = `AISS_INT_50HZ_US * `AISS_CLK_MHZ,
    parameter INT60_CYC = `AISS_INT_60HZ_US * `AISS_CLK_MHZ,
    parameter PROC_CYC  = `AISS_PROC_US * `AISS_CLK_MHZ
) (
    input  wire        REF_CLK_I,
    input  wire        NRST_I,
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output wire        PREADY_O,
    output wire        PSLVERR_O,
    input  wire        LOAD_OK_I,    // load supply pin, async
    output reg         CONV_START_O, // start one conversion
    output reg  [2:0]  CONV_CH_O,    // channel being converted
    input  wire        CONV_DONE_I,  // converter finished
    input  wire [15:0] CONV_DATA_I,  // raw converted value
    output reg         VAL_STB_O,    // value to backplane bus
    output reg  [2:0]  VAL_CH_O,
    output reg  [15:0] VAL_DATA_O,
    output wire [1:0]  RANGE_O,      // reference junction mode
    output wire [3:0]  RANGE_SEL_O,
    output wire        SUP_60HZ_O,
    output wire [15:0] REF_TEMP_O
);
    // ********************************************
    // states
    // ********************************************
    localparam [3:0] S_PICK = 4'h1;
    localparam [3:0] S_CONV = 4'h2;
    localparam [3:0] S_PROC = 4'h4;
    localparam [3:0] S_SEND = 4'h8;
    localparam CW = 32;
    // the wrap edge itself counts as the first cycle of a new scan
    localparam [CW-1:0] CYC_ONE = {{(CW-1){1'b0}}, 1'b1};

    // ********************************************
    // load supply synchroniser
    // ********************************************
    reg  ld_s1_q;                  // first stage, read only by second
    reg  ld_s2_q;
    always @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ld_s1_q <= 1'b0;
            ld_s2_q <= 1'b0;
        end else begin
            ld_s1_q <= LOAD_OK_I;
            ld_s2_q <= ld_s1_q;
        end
    end

    // ********************************************
    // register file
    // ********************************************
    reg  [NCH-1:0] act_q;          // channel activated
    reg  [1:0]     smo_q;          // smoothing level
    reg            fmt_q;          // 1 = legacy format
    reg            sup_q;          // 1 = 60 Hz suppression
    reg  [1:0]     rj_q;           // reference junction mode
    reg  [3:0]     rng_q;          // measurement range
    reg  [15:0]    reft_q;         // reference temperature
    reg            run_q;          // controller run flag
    reg  [NCH-1:0] pend_q;         // first conversion pending
    reg  [CW-1:0]  cyc_q;          // last module cycle length
    reg  [CW-1:0]  cyc_cnt_q;
    wire           acc_w;
    wire           wr_w;
    wire           param_w;
    reg  [3:0]     def_rng;

    assign acc_w     = PSEL_I & PENABLE_I;
    assign wr_w      = acc_w & PWRITE_I;
    assign PREADY_O  = 1'b1;       // zero wait states
    assign PSLVERR_O = 1'b0;
    assign param_w   = wr_w && PADDR_I == `AISS_CTRL_ADDR &&
                       PWDATA_I[`AISS_CTRL_PARAM];

    // default range per module type
    always @* begin
        case (MOD_TYPE)
            `AISS_TYPE_VOLT: def_rng = `AISS_RNG_10V;
            `AISS_TYPE_CURR: def_rng = `AISS_RNG_4_20MA;
            `AISS_TYPE_RES:  def_rng = `AISS_RNG_PT100;
            default:         def_rng = `AISS_RNG_TC_K;
        endcase
    end

    // configuration writes; reset yields defaults
    always @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            act_q  <= {NCH{1'b1}};
            smo_q  <= `AISS_SMO_NONE;
            fmt_q  <= `AISS_FMT_PRIMARY;
            sup_q  <= `AISS_SUP_50HZ;
            rj_q   <= `AISS_RJ_NONE;
            reft_q <= `AISS_REFT_RST;
            rng_q  <= 4'h0;
            run_q  <= 1'b0;
        end else if (wr_w) begin
            if (PADDR_I == `AISS_CFG_ADDR) begin
                act_q <= PWDATA_I[`AISS_CFG_ACT_LO +: NCH];
                smo_q <= PWDATA_I[`AISS_CFG_SMO_HI:`AISS_CFG_SMO_LO];
                fmt_q <= PWDATA_I[`AISS_CFG_FMT];
                sup_q <= PWDATA_I[`AISS_CFG_SUP];
                rj_q  <= PWDATA_I[`AISS_CFG_RJ_HI:`AISS_CFG_RJ_LO];
                rng_q <= PWDATA_I[`AISS_CFG_RNG_HI:`AISS_CFG_RNG_LO];
            end
            if (PADDR_I == `AISS_REFT_ADDR) begin
                reft_q <= PWDATA_I[15:0];
            end
            if (PADDR_I == `AISS_CTRL_ADDR) begin
                run_q <= PWDATA_I[`AISS_CTRL_RUN];
            end
        end
    end
    // range zero means use module default
    assign RANGE_SEL_O = (rng_q == 4'h0) ? def_rng : rng_q;
    assign RANGE_O     = rj_q;
    assign SUP_60HZ_O  = sup_q;
    assign REF_TEMP_O  = reft_q;

    // read mux
    always @* begin
        PRDATA_O = 32'h0000_0000;
        case (PADDR_I)
            `AISS_CTRL_ADDR: PRDATA_O = {30'h0, run_q, 1'b0};
            `AISS_CFG_ADDR:  PRDATA_O = {12'h0, RANGE_SEL_O, 2'h0, rj_q,
                                         sup_q, fmt_q, smo_q,
                                         {(8-NCH){1'b0}}, act_q};
            `AISS_STAT_ADDR: PRDATA_O = {15'h0, ld_s2_q,
                                         {(16-NCH){1'b0}}, pend_q};
            `AISS_REFT_ADDR: PRDATA_O = {16'h0, reft_q};
            `AISS_TIME_ADDR: PRDATA_O = cyc_q;
            default:         PRDATA_O = 32'h0000_0000;
        endcase
    end

    // ********************************************
    // scan sequencer
    // ********************************************
    reg  [3:0]  st_q;
    reg  [2:0]  ch_q;
    reg  [CW-1:0] tmr_q;
    reg  [15:0] raw_q;
    reg         pend_sel;
    wire [CW-1:0] int_cyc;
    wire [15:0] filt;
    wire [16*NCH-1:0] filt_all;    // one smoother per channel
    wire        ld_flt;            // last processing cycle
    genvar      g;
    wire [15:0] fmt_val;
    wire [2:0]  ch_nx;

    // integration time set by suppression frequency
    assign int_cyc = sup_q ? INT60_CYC : INT50_CYC;
    assign ch_nx   = (ch_q == NCH - 1) ? 3'h0 : ch_q + 3'h1;

    assign ld_flt = st_q == S_PROC && tmr_q == {CW{1'b0}};
    // a shared filter would blend channels, so each has its own
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_smooth
            aiss_smooth #(.W(16)) u_smooth (
                .clk_i   (REF_CLK_I),
                .nrst_i  (NRST_I),
                .load_i  (ld_flt && ch_q == g),
                .seed_i  (pend_q[g]),
                .level_i (smo_q),
                .raw_i   (raw_q),
                .val_o   (filt_all[16*g +: 16])
            );
        end
    endgenerate
    assign filt = filt_all[16*ch_q +: 16];
    // legacy format is the value halved
    assign fmt_val = fmt_q ? {filt[15], filt[15:1]} : filt;

    // one channel at a time; inactive ones skipped
    always @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_q <= S_PICK;
            ch_q <= 3'h0;
            tmr_q <= {CW{1'b0}};
            raw_q <= 16'h0000;
            pend_q <= {NCH{1'b1}};
            CONV_START_O <= 1'b0;
            CONV_CH_O <= 3'h0;
            VAL_STB_O <= 1'b0;
            VAL_CH_O <= 3'h0;
            VAL_DATA_O <= `AISS_INVALID;
            cyc_q <= {CW{1'b0}};
            cyc_cnt_q <= CYC_ONE;
        end else begin
            CONV_START_O <= 1'b0;
            VAL_STB_O <= 1'b0;
            cyc_cnt_q <= cyc_cnt_q + 1'b1;
            if (param_w) begin
                pend_q <= {NCH{1'b1}};
            end
            case (st_q)
                S_PICK: begin
                    if (act_q[ch_q]) begin
                        CONV_START_O <= 1'b1;
                        CONV_CH_O <= ch_q;
                        tmr_q <= int_cyc;
                        st_q <= S_CONV;
                    end else begin
                        ch_q <= ch_nx;
                        if (ch_nx == 3'h0) begin
                            cyc_q <= cyc_cnt_q;
                            cyc_cnt_q <= CYC_ONE;
                        end
                    end
                end
                S_CONV: begin
                    if (tmr_q != {CW{1'b0}}) begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                    if (CONV_DONE_I && tmr_q == {CW{1'b0}}) begin
                        raw_q <= CONV_DATA_I;
                        tmr_q <= PROC_CYC;
                        st_q <= S_PROC;
                    end
                end
                S_PROC: begin
                    if (tmr_q != {CW{1'b0}}) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else begin
                        st_q <= S_SEND;
                    end
                end
                S_SEND: begin
                    VAL_STB_O <= 1'b1;
                    VAL_CH_O <= ch_q;
                    if (!ld_s2_q || pend_q[ch_q]) begin
                        VAL_DATA_O <= `AISS_INVALID;
                    end else begin
                        VAL_DATA_O <= fmt_val;
                    end
                    if (!param_w) begin
                        pend_q[ch_q] <= 1'b0;
                    end
                    ch_q <= ch_nx;
                    if (ch_nx == 3'h0) begin
                        cyc_q <= cyc_cnt_q;
                        cyc_cnt_q <= CYC_ONE;
                    end
                    st_q <= S_PICK;
                end
                default: st_q <= S_PICK;
            endcase
        end
    end
endmodule // aiss_top

// File: dv/aiss_conv_model.sv
`timescale 1ns/1ps
// ***********************************************
// converter stand-in, answers promptly or slowly
// ***********************************************
module aiss_conv_model (
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire        start_i,
    output reg         done_o,
    output reg  [15:0] data_o
);
    integer seed = 87491; // fixed seed
    integer wait_q;       // cycles left until the answer
    // done is held as a level until the next start
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_o <= 1'b0;
            data_o <= 16'h5A5A;
            wait_q <= 0;
        end else if (start_i) begin
            done_o <= 1'b0;
            wait_q <= 1 + ($random(seed) & 31);
        end else if (wait_q == 1) begin
            done_o <= 1'b1;
            wait_q <= 0;
            // positive only, so the legacy shift has one reading
            data_o <= $random(seed) & 16'h7FFE;
        end else begin
            if (wait_q > 0) wait_q <= wait_q - 1;
            // no stale value while no answer stands
            if (!done_o) data_o <= ~data_o;
        end
    end
endmodule // aiss_conv_model

// File: dv/aiss_chk_props.sv
`timescale 1ns/1ps
`include "aiss_regs.vh"
// ***********************************************
// port checks of the scan sequencer
// ***********************************************
module aiss_chk #(
    parameter INT60_CYC = 16,
    parameter PROC_CYC  = 5,
    parameter [1:0] MOD_TYPE = 2'h0
) (
    input wire        REF_CLK_I,
    input wire        NRST_I,
    input wire        PSEL_I,
    input wire        PENABLE_I,
    input wire        PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire        LOAD_OK_I,
    input wire        CONV_START_O,
    input wire [2:0]  CONV_CH_O,
    input wire        VAL_STB_O,
    input wire [2:0]  VAL_CH_O,
    input wire [15:0] VAL_DATA_O,
    input wire [1:0]  RANGE_O,
    input wire [3:0]  RANGE_SEL_O,
    input wire        SUP_60HZ_O,
    input wire [15:0] REF_TEMP_O
);
    localparam [3:0] RDEF = MOD_TYPE == `AISS_TYPE_TC ? `AISS_RNG_TC_K :
        MOD_TYPE == `AISS_TYPE_RES ? `AISS_RNG_PT100 :
        MOD_TYPE == `AISS_TYPE_CURR ? `AISS_RNG_4_20MA : `AISS_RNG_10V;
    wire       wr = PSEL_I && PENABLE_I && PWRITE_I; // write taken
    reg        busy_q; // a conversion is in flight
    reg [2:0]  ch_q;   // its channel
    reg [15:0] cyc_q;  // cycles since its start
    reg [2:0]  lowc_q; // cycles with load absent, saturating
    reg [7:0]  pend_q; // first conversion still owed
    reg [7:0]  act_q;  // snooped active mask
    // helper state from the ports alone
    always @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            busy_q <= 1'b0;
            ch_q <= 3'h0;
            cyc_q <= 16'h0;
            lowc_q <= 3'h0;
            pend_q <= 8'hFF;
            act_q <= 8'hFF;
        end else begin
            cyc_q <= CONV_START_O ? 16'h0 : cyc_q + 16'h1;
            if (CONV_START_O) ch_q <= CONV_CH_O;
            busy_q <= CONV_START_O | (busy_q & ~VAL_STB_O);
            lowc_q <= LOAD_OK_I ? 3'h0 : lowc_q + {2'h0, lowc_q != 3'h7};
            // parameterize in the send cycle wins
            if (wr && PADDR_I == `AISS_CTRL_ADDR && PWDATA_I[0])
                pend_q <= 8'hFF;
            else if (VAL_STB_O)
                pend_q[VAL_CH_O] <= 1'b0;
            if (wr && PADDR_I == `AISS_CFG_ADDR) act_q <= PWDATA_I[7:0];
        end
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);
    property p_serial; CONV_START_O |-> !busy_q; endproperty
    a_serial: assert property (p_serial)
        else $error("start while busy");
    property p_same_ch; VAL_STB_O |-> busy_q && VAL_CH_O == ch_q; endproperty
    a_same_ch: assert property (p_same_ch)
        else $error("strobe channel differs");
    property p_active; CONV_START_O |-> act_q[CONV_CH_O]; endproperty
    a_active: assert property (p_active)
        else $error("inactive channel started");
    property p_no_load;
        VAL_STB_O && lowc_q >= 3'h5 |-> VAL_DATA_O == `AISS_INVALID;
    endproperty
    a_no_load: assert property (p_no_load)
        else $error("value without load supply");
    property p_pending;
        VAL_STB_O && pend_q[VAL_CH_O] |-> VAL_DATA_O == `AISS_INVALID;
    endproperty
    a_pending: assert property (p_pending)
        else $error("value before first conversion");
    property p_conv_time;
        // start seen, integration, capture, processing, send, strobe
        VAL_STB_O |-> cyc_q >= INT60_CYC + PROC_CYC + 2;
    endproperty
    a_conv_time: assert property (p_conv_time)
        else $error("conversion too short");
    property p_defaults;
        $rose(NRST_I) |-> !SUP_60HZ_O && REF_TEMP_O == `AISS_REFT_RST
            && RANGE_O == `AISS_RJ_NONE;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("restart defaults wrong");
    property p_def_range; $rose(NRST_I) |-> RANGE_SEL_O == RDEF; endproperty
    a_def_range: assert property (p_def_range)
        else $error("default range wrong");
    c_invalid: cover property (VAL_STB_O && VAL_DATA_O == `AISS_INVALID);
    c_value: cover property (VAL_STB_O && VAL_DATA_O != `AISS_INVALID);
    c_cfg: cover property (wr && PADDR_I == `AISS_CFG_ADDR);
endmodule // aiss_chk
bind aiss_top aiss_chk #(.INT60_CYC(INT60_CYC), .PROC_CYC(PROC_CYC),
    .MOD_TYPE(MOD_TYPE)) u_chk (.*);

// File: dv/test_analog_input_scan_sequencer.sv
`timescale 1ns/1ps
`include "aiss_regs.vh"
module test_analog_input_scan_sequencer;
    // ***********************************************
    // stimulus, design and partner
    // ***********************************************
    reg REF_CLK_I = 1'b0, NRST_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0;
    reg PWRITE_I = 1'b0, LOAD_OK_I = 1'b1;
    reg  [11:0] PADDR_I = 12'h000;
    reg  [31:0] PWDATA_I = 32'h0;
    wire [31:0] PRDATA_O;
    wire PREADY_O, PSLVERR_O, CONV_START_O, CONV_DONE_I, VAL_STB_O, SUP_60HZ_O;
    wire [2:0]  CONV_CH_O, VAL_CH_O;
    wire [15:0] CONV_DATA_I, VAL_DATA_O, REF_TEMP_O;
    wire [1:0]  RANGE_O;
    wire [3:0]  RANGE_SEL_O;
    integer seed = 87491, err_count = 0, comparisons = 0, skip = 0;
    integer last_ch = -1, n = 0, k, m, i, w, d, e, t0 = -1, t_cyc = 0;
    integer t_last [0:7]; // cycle of each channel's last value
    reg [15:0] raw [0:7]; // last converter answer per channel
    reg [15:0] flt [0:7]; // smoothed value per channel
    reg [1:0]  smo = 2'h0; // smoothing level
    reg [3:0]  er;         // expected active range
    reg        slv;        // error flag of the last transfer
    reg [15:0] ev;        // expected value
    reg [7:0]  pend = 8'hFF, act = 8'hFF;
    reg        fmt = 1'b0;
    reg [31:0] rd, wd;
    always #4 REF_CLK_I = ~REF_CLK_I;
    // short integration so each channel takes tens of cycles
    aiss_top #(.INT50_CYC(20), .INT60_CYC(16), .PROC_CYC(5)) dut (.*);
    aiss_conv_model u_conv (.clk_i(REF_CLK_I), .nrst_i(NRST_I),
        .start_i(CONV_START_O), .done_o(CONV_DONE_I), .data_o(CONV_DATA_I));
    function integer nxt(input integer c, input [7:0] msk);
        integer s;
        begin
            nxt = c;
            for (s = 8; s >= 1; s = s - 1) if (msk[(c + s) % 8]) nxt = (c + s) % 8;
        end
    endfunction
    task chk(input bit ok, input string msg);
        begin
            comparisons = comparisons + 1;
            if (!ok) begin
                err_count = err_count + 1;
                $display("BAD %0t %s", $time, msg);
            end
        end
    endtask
    task conclude;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task apb(input w_i, input [11:0] a, input [31:0] d);
        integer t;
        begin
            @(posedge REF_CLK_I);
            PSEL_I <= 1'b1;
            PWRITE_I <= w_i;
            PADDR_I <= a;
            PWDATA_I <= d;
            @(posedge REF_CLK_I);
            PENABLE_I <= 1'b1;
            for (t = 1; t <= 50; t = t + 1) begin
                @(posedge REF_CLK_I);
                if (PREADY_O === 1'b1) t = 99;
            end
            if (t == 51) begin
                err_count = err_count + 1;
                conclude;
            end
            rd = PRDATA_O;
            slv = PSLVERR_O;
            PSEL_I <= 1'b0;
            PENABLE_I <= 1'b0;
        end
    endtask
    // ***********************************************
    // reference model, snooping bus and outputs
    // ***********************************************
    always @(posedge REF_CLK_I) begin
        if (CONV_DONE_I === 1'b1) raw[CONV_CH_O] = CONV_DATA_I;
        // values are taken the cycle they appear
        if (NRST_I && VAL_STB_O === 1'b1) begin
            // smoothing per channel, a pending channel seeds its filter
            d = raw[VAL_CH_O];
            e = flt[VAL_CH_O];
            d = (d - e) >>> smo;
            if (pend[VAL_CH_O] || smo == 2'h0) flt[VAL_CH_O] = raw[VAL_CH_O];
            else flt[VAL_CH_O] = flt[VAL_CH_O] + d[15:0];
            ev = fmt ? flt[VAL_CH_O] >> 1 : flt[VAL_CH_O];
            if (!LOAD_OK_I || pend[VAL_CH_O]) ev = 16'h7FFF;
            if (skip == 0) begin
                chk(VAL_DATA_O === ev, "value");
                if (last_ch >= 0) chk(VAL_CH_O === nxt(last_ch, act), "order");
                k = n - t_last[VAL_CH_O];
                m = $countones(act);
                if (t_last[VAL_CH_O] > 0) chk(k >= m * 21 && k <= m * 65 + 8, "cycle");
                t_last[VAL_CH_O] = n;
            end else skip = skip - 1;
            last_ch = VAL_CH_O;
            pend[VAL_CH_O] = 1'b0;
        end
        if (PSEL_I && PENABLE_I && PWRITE_I) begin
            if (PADDR_I == `AISS_CTRL_ADDR && PWDATA_I[0]) pend = 8'hFF;
            if (PADDR_I == `AISS_CFG_ADDR) begin
                act = PWDATA_I[7:0];
                fmt = PWDATA_I[10];
                smo = PWDATA_I[9:8];
                skip = 1; // the value in flight belongs to the old setup
                for (m = 0; m < 8; m = m + 1) t_last[m] = 0;
            end
        end
        // scan length measured between starts of channel zero
        if (CONV_START_O === 1'b1 && CONV_CH_O === 3'h0) begin
            if (t0 >= 0) t_cyc = n - t0;
            t0 = n;
        end
        n = n + 1;
    end
    initial begin
        for (i = 0; i < 8; i = i + 1) t_last[i] = 0;
        repeat (8) @(posedge REF_CLK_I);
        NRST_I <= 1'b1;
        apb(0, `AISS_CFG_ADDR, 0);
        chk(rd === {12'h0, `AISS_RNG_10V, 16'h00FF}, "cfg reset");
        apb(0, `AISS_REFT_ADDR, 0);
        chk(rd === 32'h0, "reft reset");
        chk(RANGE_SEL_O === `AISS_RNG_10V, "range");
        $display("test defaults done");
        apb(1, `AISS_CTRL_ADDR, 32'h1);
        for (i = 0; i < 60; i = i + 1) begin
            for (w = 0; w < 3000; w = w + 1) begin
                @(posedge REF_CLK_I);
                if (VAL_STB_O === 1'b1) w = 5000;
            end
            if (w == 3000) begin
                err_count = err_count + 1;
                conclude;
            end
            // keep bus writes clear of the next channel pick
            repeat (12) @(posedge REF_CLK_I);
            wd = $random(seed);
            case (wd[2:0])
                3'h0: LOAD_OK_I <= ~LOAD_OK_I;
                3'h1, 3'h6: begin
                    // channel zero stays active so a scan never stalls
                    wd = (wd & 32'h000F3FFF) | 32'h1;
                    er = wd[19:16] != 4'h0 ? wd[19:16] : `AISS_RNG_10V;
                    apb(1, `AISS_CFG_ADDR, wd);
                    apb(0, `AISS_CFG_ADDR, 0);
                    chk(rd[15:0] === wd[15:0], "cfg");
                    chk(rd[31:20] === wd[31:20], "cfg top");
                    chk(rd[19:16] === er, "cfg range");
                    chk(RANGE_SEL_O === er && RANGE_O === wd[13:12], "pins");
                    chk(SUP_60HZ_O === wd[11], "suppression");
                end
                3'h2, 3'h7: apb(1, `AISS_CTRL_ADDR, {30'h0, wd[4:3]});
                3'h3: begin
                    apb(0, `AISS_STAT_ADDR, 0);
                    chk(rd[7:0] === pend && rd[16] === LOAD_OK_I, "status");
                    apb(0, `AISS_TIME_ADDR, 0);
                    chk(rd === t_cyc, "cycle time");
                end
                3'h4: begin
                    apb(1, `AISS_REFT_ADDR, wd);
                    apb(0, `AISS_REFT_ADDR, 0);
                    chk(rd[15:0] === wd[15:0] && REF_TEMP_O === wd[15:0], "reft");
                end
                default: begin
                    apb(1, 12'h0FC, wd);
                    apb(0, 12'h0FC, 0);
                    chk(rd === 32'h0 && slv === 1'b0, "unmapped");
                end
            endcase
        end
        $display("test scan done");
        conclude;
    end
endmodule // test_analog_input_scan_sequencer
